/* hdl/dsa_pkg.sv */
// Shared constants and types of the dual-slope converter sequencer.
// Assumes a single converter clock; all counts are in clock cycles.
package dsa_pkg;
    // Conversion counts, 16-bit variant
    localparam int CNT_W = 17;
    localparam logic [16:0] INT_COUNT = 17'h08000;
    localparam logic [16:0] DEINT_COUNT = 17'h10000;
    localparam logic [16:0] AZ_COUNT = 17'h08000;
    localparam logic [16:0] CNT_ONE = 17'h00001;
    // Result layout
    localparam int MAG_W = 16;
    localparam int RES_W = 18;
    localparam int POL_BIT = 16;
    localparam int OVR_BIT = 17;
    localparam int GRP_W = 8;
    localparam int GRP_N = 3;
    localparam int HS_WORDS = 3;
    localparam logic [1:0] HS_LAST = 2'h2;
    // Synchronised pin vector positions
    localparam int SY_RUN = 0;
    localparam int SY_MODE = 1;
    localparam int SY_ZC = 2;
    localparam int SY_POL = 3;
    localparam int SY_RDY = 4;
    localparam int SY_CDIS = 5;
    localparam int SY_BDIS = 6;
    localparam int SY_W = 9;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0C;
    localparam logic [7:0] REG_STATE = 8'h10;
    localparam logic CTRL_RESET = 1'b1;
    localparam int IRQ_W = 3;
    localparam int IRQ_LATCH = 0;
    localparam int IRQ_OVER = 1;
    localparam int IRQ_HS_DONE = 2;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    typedef enum logic [1:0] {
        PH_AZ = 2'b00,
        PH_INT = 2'b01,
        PH_DEINT = 2'b10
    } dsa_phase_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_WAIT = 2'b01,
        HS_LOAD = 2'b10,
        HS_BUSY = 2'b11
    } dsa_hs_t;
endpackage

/* hdl/dsa_phase_timer.sv */
// Phase length counter of the converter sequencer.
// Assumes the caller clears it on every phase change.
`timescale 1ns/1ps
module dsa_phase_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic clr,
    // Count
    output logic [16:0] count
);
    logic [16:0] next_count;

    always_comb begin
        if (clr) begin
            next_count = '0;
        end else if (count != '1) begin
            next_count = count + dsa_pkg::CNT_ONE;
        end else begin
            next_count = count;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule

/* hdl/dsa_out_group.sv */
// One enable group of the three-state result outputs.
// Assumes disable inputs are already synchronised.
`timescale 1ns/1ps
module dsa_out_group #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Disables, active low enable
    input wire logic chip_disn,
    input wire logic byte_disn,
    // Data
    input wire logic [W-1:0] data_in,
    output logic [W-1:0] data_out,
    output logic oe
);
    logic next_oe;

    always_comb begin
        next_oe = !chip_disn && !byte_disn;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oe <= 1'b0;
            data_out <= '0;
        end else begin
            oe <= next_oe;
            data_out <= data_in;
        end
    end

    AST_GROUP_OE: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> oe == ($past(!chip_disn) && $past(!byte_disn)))
        else $error("Group enable does not follow the disables");
    AST_ALL_LOW: assert property (@(posedge clk) disable iff (!rstn)
        (!chip_disn && !byte_disn)[*2] |-> oe)
        else $error("Group not driven with all disables low");
endmodule

/* hdl/dsa_top.sv */
// Digital sequencer and output stage of a dual-slope integrating converter.
// Assumes comparator, polarity and pin inputs are asynchronous to MCLK.
// Operation
// - Auto-zero doubles as idle, then integrate input for fixed clock count.
// - Latch polarity, deintegrate opposite reference, count to zero crossing is result.
// - Mode low starts no new handshake, only plain three-state outputs; one already begun still sends all three words.
// - Status output rises at start of input integrate.
// - Latch result on next clock after crossing; status falls afterwards.
// - Run/hold high converts continuously; low finishes current then waits.
// - Eighteen result lines with polarity and over-range, groups of eight max.
// - Group driven only when chip and its byte disable are low.
// - All disables low drives every output as latched parallel port.
// - Result latched with mode high enters handshake at end of latch cycle.
// - Mode rising enters handshake at once, deferred past a latch cycle.
// - Handshake sends eighteen-bit result as three eight-bit words.
// - With run/hold high a conversion takes a fixed total count.
// - Run/hold low after crossing ends deintegrate, minimum auto-zero, then waits.
`timescale 1ns/1ps
module dsa_top #(
    // Phase counts, shorten in simulation
    parameter logic [16:0] INT_CYC = dsa_pkg::INT_COUNT,
    parameter logic [16:0] DEINT_CYC = dsa_pkg::DEINT_COUNT,
    parameter logic [16:0] AZ_CYC = dsa_pkg::AZ_COUNT
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic IRQ,
    // Conversion pins
    input wire logic RUN_HOLD,
    input wire logic MODE,
    input wire logic ZERO_CROSS,
    input wire logic POLARITY_IN,
    output logic AZ_PHASE,
    output logic INT_PHASE,
    output logic DEINT_PHASE,
    output logic REF_POLARITY,
    output logic CONVERSION_ACTIVE_FLAG,
    // Three-state result outputs
    input wire logic CHIP_DISN,
    input wire logic [2:0] BYTE_DISN,
    output logic [17:0] DATA_OUT,
    output logic [2:0] DATA_OE,
    // Handshake
    input wire logic HS_READY,
    output logic [7:0] HS_WORD,
    output logic HS_LOAD,
    output logic HS_ACTIVE
);
    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [8:0] sy1;
    logic [8:0] sy2;
    logic mode_d;
    logic run_s;
    logic mode_s;
    logic zc_s;
    logic mode_rise;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            sy1 <= '0;
            sy2 <= '0;
            mode_d <= 1'b0;
        end else begin
            sy1 <= {BYTE_DISN, CHIP_DISN, HS_READY, POLARITY_IN, ZERO_CROSS, MODE, RUN_HOLD};
            sy2 <= sy1;
            mode_d <= sy2[dsa_pkg::SY_MODE];
        end
    end

    assign mode_s = sy2[dsa_pkg::SY_MODE];
    assign zc_s = sy2[dsa_pkg::SY_ZC];
    assign mode_rise = mode_s && !mode_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    dsa_pkg::dsa_phase_t phase, next_phase;
    logic [16:0] cnt;
    logic cnt_clr;
    logic zc_seen, next_zc_seen;
    logic pol, next_pol;
    logic [17:0] result, next_result;
    logic latch, latched;
    logic over_ev;
    logic status, next_status;
    logic soft_run;

    assign run_s = sy2[dsa_pkg::SY_RUN] && soft_run;

    dsa_phase_timer u_timer (
        .clk(MCLK),
        .rstn(RESETN),
        .clr(cnt_clr),
        .count(cnt)
    );

    // Full-length deintegrate plus fixed auto-zero keeps the cycle constant
    always_comb begin
        next_phase = phase;
        next_zc_seen = zc_seen;
        next_pol = pol;
        next_result = result;
        next_status = status;
        latch = 1'b0;
        over_ev = 1'b0;
        case (phase)
            dsa_pkg::PH_AZ: begin
                if (cnt >= AZ_CYC - dsa_pkg::CNT_ONE && run_s) begin
                    next_phase = dsa_pkg::PH_INT;
                    next_status = 1'b1;
                end
            end
            dsa_pkg::PH_INT: begin
                if (cnt == INT_CYC - dsa_pkg::CNT_ONE) begin
                    next_phase = dsa_pkg::PH_DEINT;
                    next_pol = sy2[dsa_pkg::SY_POL];
                    next_zc_seen = 1'b0;
                end
            end
            dsa_pkg::PH_DEINT: begin
                if (zc_s && !zc_seen) begin
                    latch = 1'b1;
                    next_zc_seen = 1'b1;
                    next_result = {1'b0, pol, cnt[dsa_pkg::MAG_W-1:0]};
                end else if (!zc_seen && cnt == DEINT_CYC - dsa_pkg::CNT_ONE) begin
                    latch = 1'b1;
                    over_ev = 1'b1;
                    next_result = {1'b1, pol, {dsa_pkg::MAG_W{1'b1}}};
                end
                if (cnt == DEINT_CYC - dsa_pkg::CNT_ONE || (zc_seen && !run_s)) begin
                    next_phase = dsa_pkg::PH_AZ;
                end
            end
            default: begin
                next_phase = dsa_pkg::PH_AZ;
            end
        endcase
        if (latched) begin
            next_status = 1'b0;
        end
    end

    assign cnt_clr = next_phase != phase;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            phase <= dsa_pkg::PH_AZ;
            zc_seen <= 1'b0;
            pol <= 1'b0;
            result <= '0;
            latched <= 1'b0;
            status <= 1'b0;
            AZ_PHASE <= 1'b1;
            INT_PHASE <= 1'b0;
            DEINT_PHASE <= 1'b0;
            REF_POLARITY <= 1'b0;
        end else begin
            phase <= next_phase;
            zc_seen <= next_zc_seen;
            pol <= next_pol;
            result <= next_result;
            latched <= latch;
            status <= next_status;
            AZ_PHASE <= next_phase == dsa_pkg::PH_AZ;
            INT_PHASE <= next_phase == dsa_pkg::PH_INT;
            DEINT_PHASE <= next_phase == dsa_pkg::PH_DEINT;
            REF_POLARITY <= !next_pol;
        end
    end

    assign CONVERSION_ACTIVE_FLAG = status;

    ////////////////////////////////////////////////////////////////////////////////
    // Three-state result groups
    logic [17:0] grp_in;

    // Fed from the next value so the pins settle a cycle before status falls
    assign grp_in = next_result;

    genvar g;
    generate
        for (g = 0; g < dsa_pkg::GRP_N; g++) begin : g_grp
            localparam int LO = g * dsa_pkg::GRP_W;
            localparam int HI = (LO + dsa_pkg::GRP_W > dsa_pkg::RES_W) ?
                dsa_pkg::RES_W - 1 : LO + dsa_pkg::GRP_W - 1;
            dsa_out_group #(
                .W(HI - LO + 1)
            ) u_grp (
                .clk(MCLK),
                .rstn(RESETN),
                .chip_disn(sy2[dsa_pkg::SY_CDIS]),
                .byte_disn(sy2[dsa_pkg::SY_BDIS + g]),
                .data_in(grp_in[HI:LO]),
                .data_out(DATA_OUT[HI:LO]),
                .oe(DATA_OE[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Handshake
    dsa_pkg::dsa_hs_t hs, next_hs;
    logic hs_pend, next_hs_pend;
    logic [1:0] hs_idx, next_hs_idx;
    logic [7:0] next_hs_word;
    logic hs_done;
    logic rdy_s;

    assign rdy_s = sy2[dsa_pkg::SY_RDY];

    function automatic logic [7:0] hs_pick(input logic [17:0] r, input logic [1:0] i);
        logic [7:0] w;
        w = 8'h00;
        case (i)
            2'h0: w = r[7:0];
            2'h1: w = r[15:8];
            default: w = {6'h00, r[dsa_pkg::OVR_BIT], r[dsa_pkg::POL_BIT]};
        endcase
        return w;
    endfunction

    always_comb begin
        next_hs = hs;
        next_hs_idx = hs_idx;
        next_hs_pend = 1'b0;
        hs_done = 1'b0;
        case (hs)
            dsa_pkg::HS_IDLE: begin
                if (hs_pend) begin
                    next_hs = dsa_pkg::HS_WAIT;
                end else if (latch && (mode_s || mode_rise)) begin
                    next_hs_pend = 1'b1;
                end else if (mode_rise) begin
                    next_hs = dsa_pkg::HS_WAIT;
                end
                next_hs_idx = 2'h0;
            end
            dsa_pkg::HS_WAIT: begin
                if (rdy_s) begin
                    next_hs = dsa_pkg::HS_LOAD;
                end
            end
            dsa_pkg::HS_LOAD: begin
                next_hs = dsa_pkg::HS_BUSY;
            end
            dsa_pkg::HS_BUSY: begin
                if (!rdy_s) begin
                    if (hs_idx == dsa_pkg::HS_LAST) begin
                        next_hs = dsa_pkg::HS_IDLE;
                        hs_done = 1'b1;
                    end else begin
                        next_hs = dsa_pkg::HS_WAIT;
                        next_hs_idx = hs_idx + 2'h1;
                    end
                end
            end
            default: begin
                next_hs = dsa_pkg::HS_IDLE;
            end
        endcase
        next_hs_word = hs_pick(result, next_hs_idx);
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            hs <= dsa_pkg::HS_IDLE;
            hs_pend <= 1'b0;
            hs_idx <= 2'h0;
            HS_WORD <= 8'h00;
            HS_LOAD <= 1'b0;
            HS_ACTIVE <= 1'b0;
        end else begin
            hs <= next_hs;
            hs_pend <= next_hs_pend;
            hs_idx <= next_hs_idx;
            HS_WORD <= next_hs_word;
            HS_LOAD <= next_hs == dsa_pkg::HS_LOAD;
            HS_ACTIVE <= next_hs != dsa_pkg::HS_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register port and interrupt
    logic [2:0] irq_st, next_irq_st;
    logic [2:0] irq_mask, next_irq_mask;
    logic next_soft_run;
    logic [31:0] next_rdata;
    logic [2:0] irq_ev;

    assign irq_ev = {hs_done, over_ev, latch};

    always_comb begin
        next_soft_run = soft_run;
        next_irq_mask = irq_mask;
        next_irq_st = irq_st;
        next_rdata = 32'h00000000;
        if (REG_WR && REG_ADDR == dsa_pkg::REG_CTRL) begin
            next_soft_run = REG_WDATA[0];
        end
        if (REG_WR && REG_ADDR == dsa_pkg::REG_IRQ_MASK) begin
            next_irq_mask = REG_WDATA[dsa_pkg::IRQ_W-1:0];
        end
        if (REG_WR && REG_ADDR == dsa_pkg::REG_IRQ_STATUS) begin
            next_irq_st = irq_st & ~REG_WDATA[dsa_pkg::IRQ_W-1:0];
        end
        // Set after clear so a same-cycle event survives
        next_irq_st = next_irq_st | irq_ev;
        if (REG_RD) begin
            case (REG_ADDR)
                dsa_pkg::REG_CTRL: next_rdata = {31'h00000000, soft_run};
                dsa_pkg::REG_IRQ_STATUS: next_rdata = {29'h00000000, irq_st};
                dsa_pkg::REG_IRQ_MASK: next_rdata = {29'h00000000, irq_mask};
                dsa_pkg::REG_RESULT: next_rdata = {14'h0000, result};
                dsa_pkg::REG_STATE: next_rdata = {28'h0000000, HS_ACTIVE, status, phase};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            soft_run <= dsa_pkg::CTRL_RESET;
            irq_mask <= dsa_pkg::IRQ_MASK_RESET;
            irq_st <= '0;
            REG_RDATA <= 32'h00000000;
            IRQ <= 1'b0;
        end else begin
            soft_run <= next_soft_run;
            irq_mask <= next_irq_mask;
            irq_st <= next_irq_st;
            REG_RDATA <= next_rdata;
            IRQ <= |(next_irq_st & next_irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_INT_LEN: assert property (@(posedge MCLK) disable iff (!RESETN)
        (phase == dsa_pkg::PH_INT && cnt == INT_CYC - dsa_pkg::CNT_ONE)
        |=> phase == dsa_pkg::PH_DEINT && INT_PHASE == 1'b0)
        else $error("Integrate phase length wrong");
    AST_RESULT_COUNT: assert property (@(posedge MCLK) disable iff (!RESETN)
        (latch && !over_ev) |=> result[15:0] == $past(cnt[15:0]) && latched)
        else $error("Result is not the count to crossing");
    AST_HS_OFF: assert property (@(posedge MCLK) disable iff (!RESETN)
        (!mode_s && !hs_pend && hs == dsa_pkg::HS_IDLE) |=> !HS_ACTIVE)
        else $error("Handshake active with mode low");
    AST_STATUS_RISE: assert property (@(posedge MCLK) disable iff (!RESETN)
        (phase == dsa_pkg::PH_AZ && next_phase == dsa_pkg::PH_INT)
        |=> status && INT_PHASE)
        else $error("Status not raised at integrate start");
    AST_STATUS_FALL: assert property (@(posedge MCLK) disable iff (!RESETN)
        latch |=> status ##1 !status && $stable(result))
        else $error("Status fall not one cycle after latch");
    AST_HOLD: assert property (@(posedge MCLK) disable iff (!RESETN)
        (phase == dsa_pkg::PH_AZ && !run_s) |=> phase == dsa_pkg::PH_AZ)
        else $error("Conversion started while held");
    AST_TERM: assert property (@(posedge MCLK) disable iff (!RESETN)
        (phase == dsa_pkg::PH_DEINT && zc_seen && !run_s) |=> AZ_PHASE)
        else $error("Deintegrate not ended on hold");
    AST_OVERLOAD: assert property (@(posedge MCLK) disable iff (!RESETN)
        (phase == dsa_pkg::PH_DEINT && !zc_seen && !zc_s
        && cnt == DEINT_CYC - dsa_pkg::CNT_ONE)
        |=> result[dsa_pkg::OVR_BIT] && AZ_PHASE)
        else $error("Overload not flagged");
    AST_HS_RISE: assert property (@(posedge MCLK) disable iff (!RESETN)
        (hs == dsa_pkg::HS_IDLE && !hs_pend && mode_rise && !latch) |=> HS_ACTIVE)
        else $error("Handshake not entered on mode rise");
    AST_HS_LATCH: assert property (@(posedge MCLK) disable iff (!RESETN)
        (hs == dsa_pkg::HS_IDLE && !hs_pend && latch && mode_s)
        |=> !HS_ACTIVE ##1 HS_ACTIVE)
        else $error("Handshake entry not at end of latch cycle");
    AST_HS_WORDS: assert property (@(posedge MCLK) disable iff (!RESETN)
        hs_done |-> hs_idx == dsa_pkg::HS_LAST)
        else $error("Handshake ended before three words");
endmodule

/* bench/dsa_tx_model.sv */
// Transmitter buffer model on the handshake side of the converter.
// Assumes load pulses of one MCLK cycle; stall lengthens each transmit.
`timescale 1ns/1ps
module dsa_tx_model (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Handshake
    input wire logic [7:0] HS_WORD,
    input wire logic HS_LOAD,
    output logic HS_READY,
    // Pace
    input wire logic [3:0] stall
);
    logic [7:0] words [0:7];
    int n;
    int busy;
    ////////////////////////////////////////
    // Empty flag held low for a whole transmit, never a one-cycle blip
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            n <= 0;
            busy <= 0;
            HS_READY <= 1'b1;
        end else if (HS_LOAD) begin
            words[n % 8] <= HS_WORD;
            n <= n + 1;
            busy <= 4 + int'(stall);
            HS_READY <= 1'b0;
        end else if (busy > 1) begin
            busy <= busy - 1;
        end else if (busy == 1) begin
            busy <= 0;
            HS_READY <= 1'b1;
        end
    end
endmodule

/* bench/dsa_top_tb_top.sv */
// Self-checking bench of the converter sequencer top.
// Assumes shortened phase counts and the transmitter model.
`timescale 1ns/1ps
module dsa_top_tb_top;
    localparam int AZ = 16;
    localparam int IN = 16;
    localparam int DE = 32;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic run_hold = 1'b1;
    logic mode = 1'b0;
    logic zero_cross = 1'b0;
    logic pol_in = 1'b1;
    logic chip_disn = 1'b0;
    logic [2:0] byte_disn = 3'h0;
    logic [3:0] stall = 4'h0;
    logic [31:0] reg_rdata;
    logic irq, az_ph, int_ph, deint_ph, ref_pol, act;
    logic [17:0] data_out;
    logic [2:0] data_oe;
    logic hs_ready, hs_load, hs_active;
    logic [7:0] hs_word;
    logic [17:0] r1, r2;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int s1, s2;

    dsa_top #(.INT_CYC(17'h00010), .DEINT_CYC(17'h00020), .AZ_CYC(17'h00010)) DUT (
        .MCLK(mclk), .RESETN(resetn),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .IRQ(irq),
        .RUN_HOLD(run_hold), .MODE(mode), .ZERO_CROSS(zero_cross), .POLARITY_IN(pol_in),
        .AZ_PHASE(az_ph), .INT_PHASE(int_ph), .DEINT_PHASE(deint_ph),
        .REF_POLARITY(ref_pol), .CONVERSION_ACTIVE_FLAG(act),
        .CHIP_DISN(chip_disn), .BYTE_DISN(byte_disn), .DATA_OUT(data_out), .DATA_OE(data_oe),
        .HS_READY(hs_ready), .HS_WORD(hs_word), .HS_LOAD(hs_load), .HS_ACTIVE(hs_active)
    );

    dsa_tx_model TX (
        .MCLK(mclk), .RESETN(resetn), .HS_WORD(hs_word), .HS_LOAD(hs_load),
        .HS_READY(hs_ready), .stall(stall)
    );

    ////////////////////////////////////////
    initial begin
        forever #2.5 mclk = ~mclk;
    end

    // Hang guard, far above the longest run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask

    ////////////////////////////////////////
    // One conversion; crossing d cycles into deintegrate, none if d >= DE
    task automatic conv(input int d, output logic [17:0] r, output int s);
        int k;
        logic [17:0] prev;
        for (k = 0; k < 300 && int_ph !== 1'b0; k++) @(negedge mclk);
        for (k = 0; k < 300 && int_ph !== 1'b1; k++) @(negedge mclk);
        s = cyc;
        chk(act, 1'b1);
        for (k = 0; k < 300 && int_ph === 1'b1; k++) @(negedge mclk);
        chk(k, IN);
        chk(deint_ph, 1'b1);
        chk(ref_pol, !pol_in);
        if (d < DE) begin
            repeat (d) @(posedge mclk);
            zero_cross <= 1'b1;
        end
        prev = data_out;
        for (k = 0; k < 300 && act === 1'b1; k++) begin
            prev = data_out;
            @(negedge mclk);
        end
        chk(data_out, prev);
        r = data_out;
        @(posedge mclk);
        zero_cross <= 1'b0;
    endtask

    task automatic chk_words(input int b, input logic [17:0] r);
        chk(TX.n - b, 3);
        chk(TX.words[b % 8], r[7:0]);
        chk(TX.words[(b + 1) % 8], r[15:8]);
        chk(TX.words[(b + 2) % 8], {6'h00, r[17:16]});
    endtask

    ////////////////////////////////////////
    task automatic t_conv();
        conv(5, r1, s1);
        conv(9, r2, s2);
        chk(s2 - s1, AZ + IN + DE);
        chk(r2[15:0] - r1[15:0], 4);
        chk(r2[17:16], {1'b0, pol_in});
        chk(TX.n, 0);
    endtask

    task automatic t_over();
        pol_in <= 1'b0;
        conv(DE, r1, s1);
        chk(r1, {2'b10, 16'hFFFF});
    endtask

    task automatic t_hold();
        int k;
        int n;
        conv(3, r1, s1);
        run_hold <= 1'b0;
        @(negedge mclk);
        for (k = 0; k < 20 && deint_ph === 1'b1; k++) @(negedge mclk);
        chk(k < 6, 1'b1);
        n = 0;
        repeat (80) begin
            @(negedge mclk);
            if (int_ph !== 1'b0) n++;
        end
        chk(n, 0);
        chk(az_ph, 1'b1);
    endtask

    task automatic t_irq();
        logic [31:0] d;
        bus_rd(dsa_pkg::REG_IRQ_STATUS, d);
        chk(d[1:0], 2'h3);
        chk(irq, 1'b0);
        bus_rd(dsa_pkg::REG_IRQ_MASK, d);
        chk(d, 32'h0);
        bus_rd(dsa_pkg::REG_CTRL, d);
        chk(d, 32'h1);
        bus_rd(8'h14, d);
        chk(d, 32'h0);
        bus_wr(dsa_pkg::REG_IRQ_MASK, 32'h2);
        repeat (3) @(negedge mclk);
        chk(irq, 1'b1);
        bus_wr(dsa_pkg::REG_IRQ_STATUS, 32'h2);
        repeat (3) @(negedge mclk);
        chk(irq, 1'b0);
        bus_rd(dsa_pkg::REG_IRQ_STATUS, d);
        chk(d[1:0], 2'h1);
    endtask

    task automatic t_oe();
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            chip_disn <= i[3];
            byte_disn <= i[2:0];
            repeat (5) @(negedge mclk);
            chk(data_oe, i[3] ? 3'h0 : 3'h7 ^ i[2:0]);
        end
        @(posedge mclk);
        chip_disn <= 1'b0;
        byte_disn <= 3'h0;
        repeat (5) @(negedge mclk);
        chk(data_oe, 3'h7);
        chk(data_out, r1);
    endtask

    task automatic t_hs();
        int k;
        int b;
        logic [31:0] d;
        b = TX.n;
        @(posedge mclk);
        mode <= 1'b1;
        for (k = 0; k < 20 && hs_active !== 1'b1; k++) @(negedge mclk);
        chk(k < 8, 1'b1);
        for (k = 0; k < 300 && hs_active === 1'b1; k++) @(negedge mclk);
        chk_words(b, r1);
        b = TX.n;
        @(posedge mclk);
        stall <= 4'h9;
        run_hold <= 1'b1;
        conv(7, r2, s2);
        @(negedge mclk);
        chk(hs_active, 1'b1);
        @(posedge mclk);
        run_hold <= 1'b0;
        for (k = 0; k < 300 && hs_active === 1'b1; k++) @(negedge mclk);
        chk_words(b, r2);
        bus_rd(dsa_pkg::REG_IRQ_STATUS, d);
        chk(d[2], 1'b1);
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        t_conv();
        t_over();
        t_hold();
        t_irq();
        t_oe();
        t_hs();
        conclude();
    end
endmodule
